// ---- verilog/dpsc_defs.vh ----
// dpsc_defs.vh: constants of the dpll output, lock and slope block
// assumes a 20 MHz system clock and an 8 kHz frame-rate reference
`ifndef DPSC_DEFS_VH
`define DPSC_DEFS_VH

// clock and frame timing
`define DPSC_MCLK_HZ        20000000
`define DPSC_FRAME_HZ       8000
`define DPSC_FRAME_NS       125000
`define DPSC_NOM_STEP       (((64'h1)<<32)*`DPSC_FRAME_HZ/`DPSC_MCLK_HZ)
`define DPSC_LOCK_WIN_MS    4
`define DPSC_LOCK_WIN_CYC   (`DPSC_MCLK_HZ/1000*`DPSC_LOCK_WIN_MS)

// frame pulse widths in ns and their frame-phase thresholds
`define DPSC_FPW_WIDE_NS    244
`define DPSC_FPW_MID_NS     122
`define DPSC_FPW_NARROW_NS  61
`define DPSC_FPW_TINY_NS    30
`define DPSC_FPW_SONET_NS   51
`define DPSC_FP_THR(ns)     (((64'h1)<<32)*(ns)/`DPSC_FRAME_NS)

// apb register offsets
`define DPSC_OFS_LR         8'h00
`define DPSC_OFS_BW         8'h04
`define DPSC_OFS_THR        8'h08
`define DPSC_OFS_INT        8'h0C
`define DPSC_OFS_SLEW       8'h10
`define DPSC_OFS_RCC        8'h14
`define DPSC_OFS_RCS        8'h18
`define DPSC_OFS_OCFG       8'h1C

// reset values and slew limit ceiling
`define DPSC_RST_LR         14'h0370
`define DPSC_RST_BW         16'h0002
`define DPSC_RST_THR        16'h0100
`define DPSC_RST_INT        8'h04
`define DPSC_RST_SLEW       9'h060
`define DPSC_RST_RCC        8'h00
`define DPSC_RST_OCFG       8'h00
`define DPSC_SLEW_MAX       9'h140

// field positions
`define DPSC_BW_BYP_BIT     13
`define DPSC_RCC_REALIGN    7
`define DPSC_RCC_REFSEL     2
`define DPSC_RCS_LOCK       0
`define DPSC_RCS_BUSY       1
`define DPSC_RCS_REFSEL     2

// timing modes
`define DPSC_MODE_NORMAL    2'h0
`define DPSC_MODE_HOLD      2'h1
`define DPSC_MODE_FREE      2'h2

`endif

// ---- verilog/dpsc_top.v ----
// dpsc_top.v: dpll output generation, loop control, lock detect, slope limit
// assumes an apb master on mclk and 8 kHz reference pins asynchronous to mclk
//
// How it works
// - all outputs come from one frame-phase accumulator locked to the reference
// - fixed 4.096, 8.192, 16.384 and 19.44 MHz clock outputs
// - one clock selects 4.096/8.192/16.384/32.768; another 1.544 or 2.048
// - three fixed 8 kHz frame pulses 244, 122 and 61 ns wide
// - one frame pulse selects 122/61/30 ns; another is fixed 51 ns
// - 14-bit locking range clamps frequency correction, about 372 ppm maximum
// - locking range resets to about 20 ppm
// - bits 3..0 of bandwidth register pick one of 16 corner steps
// - corner frequency resets to step 2, about 1.9 Hz
// - lock declared when phase error stays below threshold long enough
// - phase error judged in 4 ms windows
// - threshold and interval each have their own register
// - lock state readable in the reference change status register
// - rearrangement recaptures phase offset so outputs do not jump
// - bit 7 of reference change control realigns to nearest reference edge
// - slew register limits phase correction, at most 186 ppm
// - bit 13 of bandwidth register bypasses the slope limiter
// - slew limit resets to about 56 ppm
// - holdover replays frequency stored one window before the last store
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_defs.vh"

module dpsc_top #(
  parameter LOCK_WIN_CYC = `DPSC_LOCK_WIN_CYC
) (
  input  wire        mclk,
  input  wire        nrst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  input  wire [1:0]  ref_in,
  output reg         clk_out_a,
  output reg         clk_out_b,
  output reg         clk_out_c,
  output reg         clk_out_selectable,
  output reg         clk_out_line_rate,
  output reg         clk_out_sonet_rate,
  output reg         frame_pulse_wide,
  output reg         frame_pulse_mid,
  output reg         frame_pulse_narrow,
  output reg         frame_pulse_selectable,
  output reg         frame_pulse_sonet
);

  localparam [63:0] NOM64   = `DPSC_NOM_STEP;
  localparam [31:0] NOM     = NOM64[31:0];
  localparam [63:0] T_WIDE  = `DPSC_FP_THR(`DPSC_FPW_WIDE_NS);
  localparam [63:0] T_MID   = `DPSC_FP_THR(`DPSC_FPW_MID_NS);
  localparam [63:0] T_NAR   = `DPSC_FP_THR(`DPSC_FPW_NARROW_NS);
  localparam [63:0] T_TINY  = `DPSC_FP_THR(`DPSC_FPW_TINY_NS);
  localparam [63:0] T_SON   = `DPSC_FP_THR(`DPSC_FPW_SONET_NS);
  localparam integer WIN_LAST = LOCK_WIN_CYC - 1;
  localparam [16:0] WIN_MAX = WIN_LAST[16:0];

  // software registers
  reg  [13:0] locking_range_reg;
  reg  [15:0] loop_bandwidth_ctrl_reg;
  reg  [15:0] lock_threshold_reg;
  reg  [7:0]  lock_interval_reg;
  reg  [8:0]  slew_limit_reg;
  reg  [7:0]  ref_change_ctrl_reg;
  reg  [7:0]  out_cfg_r;

  // loop state
  reg  [31:0] frame_ph_r;
  reg  [31:0] ph_off_r;
  reg  signed [31:0] prop_r;
  reg  [23:0] freq_int_r;
  reg  [23:0] hist_new_r;
  reg  [23:0] hist_old_r;
  reg         started_r;
  reg         rearr_r;
  reg  [1:0]  mode_d_r;
  reg         sel_d_r;
  reg         lvl_d_r;

  // lock detector state
  reg  [16:0] win_cnt_r;
  reg         win_bad_r;
  reg         win_seen_r;
  reg  [7:0]  good_cnt_r;
  reg         lock_r;

  wire [1:0]  ref_lvl;
  wire [1:0]  mode;
  wire        ref_sel;
  wire        phase_realign_cmd;
  wire        slope_limiter_bypass;
  wire [3:0]  corner_freq_select;

  assign mode                 = ref_change_ctrl_reg[1:0];
  assign ref_sel              = ref_change_ctrl_reg[`DPSC_RCC_REFSEL];
  assign phase_realign_cmd    = ref_change_ctrl_reg[`DPSC_RCC_REALIGN];
  assign slope_limiter_bypass = loop_bandwidth_ctrl_reg[`DPSC_BW_BYP_BIT];
  assign corner_freq_select   = loop_bandwidth_ctrl_reg[3:0];

  // reference pins: three stages, level accepted when stages 2 and 3 agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      reg [2:0] sh_r;
      reg       lvl_r;
      always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          sh_r  <= 3'h0;
          lvl_r <= 1'b0;
        end else begin
          sh_r <= {sh_r[1:0], ref_in[gi]};
          if (sh_r[1] == sh_r[2])
            lvl_r <= sh_r[2];
        end
      end
      assign ref_lvl[gi] = lvl_r;
    end
  endgenerate

  wire        lvl      = ref_lvl[ref_sel];
  wire        ref_edge = lvl & ~lvl_d_r;
  wire        normal   = (mode == `DPSC_MODE_NORMAL);

  // phase detector: output frame phase against reference edge
  wire [31:0] err_u = frame_ph_r - ph_off_r;
  wire signed [31:0] serr = err_u;
  wire [31:0] aerr = serr[31] ? (32'h0 - err_u) : err_u;
  wire        over_thr = aerr[31:16] > lock_threshold_reg;

  // loop gains scale with corner step; each step doubles bandwidth
  wire [4:0]  sh_p = 5'h11 - {1'b0, corner_freq_select};
  wire [4:0]  sh_i = 5'h18 - {1'b0, corner_freq_select};
  wire signed [31:0] p_raw = serr >>> sh_p;
  wire signed [31:0] i_raw = serr >>> sh_i;

  // slope limiter
  wire [8:0]  slew_eff = (slew_limit_reg > `DPSC_SLEW_MAX) ?
                         `DPSC_SLEW_MAX : slew_limit_reg;
  wire signed [31:0] s_pos = {23'h0, slew_eff};
  wire signed [31:0] s_neg = 32'sh0 - s_pos;
  reg  signed [31:0] p_lim;
  always @* begin
    p_lim = p_raw;
    if (!slope_limiter_bypass) begin
      if (p_raw > s_pos)
        p_lim = s_pos;
      else if (p_raw < s_neg)
        p_lim = s_neg;
    end
  end

  // frequency integrator clamped to the locking range
  wire signed [31:0] r_pos = {18'h0, locking_range_reg};
  wire signed [31:0] r_neg = 32'sh0 - r_pos;
  wire signed [31:0] f_sum = $signed({{8{freq_int_r[23]}}, freq_int_r}) + i_raw;
  reg  signed [31:0] f_lim;
  always @* begin
    f_lim = f_sum;
    if (f_sum > r_pos)
      f_lim = r_pos;
    else if (f_sum < r_neg)
      f_lim = r_neg;
  end

  // integrator lsb to step units: x*5/128, so 16383 maps to about 372 ppm
  function [31:0] f2off;
    input [23:0] f;
    reg   [26:0] f5;
    begin
      f5    = {f[23], f, 2'b00} + {{3{f[23]}}, f};
      f2off = {{9{f5[26]}}, f5[26:4]} >> 3 |
              ({32{f5[26]}} & 32'hE0000000);
    end
  endfunction

  reg  [31:0] offset;
  always @* begin
    case (mode)
      `DPSC_MODE_NORMAL: offset = f2off(freq_int_r) + prop_r;
      `DPSC_MODE_HOLD:   offset = f2off(hist_old_r);
      default:           offset = 32'h0;
    endcase
  end

  wire [31:0] frame_ph_nxt = frame_ph_r + NOM + offset;
  wire        wrap         = frame_ph_nxt < frame_ph_r;

  // phase loop, rearrangement capture and realign
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      frame_ph_r <= 32'h0;
      ph_off_r   <= 32'h0;
      prop_r     <= 32'sh0;
      freq_int_r <= 24'h0;
      started_r  <= 1'b0;
      rearr_r    <= 1'b0;
      mode_d_r   <= `DPSC_MODE_NORMAL;
      sel_d_r    <= 1'b0;
      lvl_d_r    <= 1'b0;
    end else begin
      frame_ph_r <= frame_ph_nxt;
      lvl_d_r    <= lvl;
      mode_d_r   <= mode;
      sel_d_r    <= ref_sel;
      if (mode != mode_d_r || ref_sel != sel_d_r) begin
        rearr_r <= 1'b1;
        prop_r  <= 32'sh0;
      end else if (ref_edge && normal) begin
        if (rearr_r || !started_r) begin
          // take the present offset as zero so the outputs hold phase
          ph_off_r  <= frame_ph_r;
          prop_r    <= 32'sh0;
          rearr_r   <= 1'b0;
          started_r <= 1'b1;
        end else if (phase_realign_cmd) begin
          ph_off_r <= 32'h0;
        end else begin
          prop_r     <= p_lim;
          freq_int_r <= f_lim[23:0];
        end
      end
    end
  end

  // lock detector over 4 ms windows
  wire win_end = (win_cnt_r == WIN_MAX);
  wire win_bad = win_bad_r || (ref_edge && normal && over_thr) ||
                 !(win_seen_r || ref_edge) || !normal || rearr_r;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      win_cnt_r  <= 17'h0;
      win_bad_r  <= 1'b0;
      win_seen_r <= 1'b0;
      good_cnt_r <= 8'h0;
      lock_r     <= 1'b0;
      hist_new_r <= 24'h0;
      hist_old_r <= 24'h0;
    end else if (win_end) begin
      win_cnt_r  <= 17'h0;
      win_bad_r  <= 1'b0;
      win_seen_r <= 1'b0;
      if (win_bad) begin
        good_cnt_r <= 8'h0;
        lock_r     <= 1'b0;
      end else begin
        if (good_cnt_r != 8'hFF)
          good_cnt_r <= good_cnt_r + 8'h01;
        if (good_cnt_r >= lock_interval_reg - 8'h01)
          lock_r <= 1'b1;
      end
      // keep two snapshots; the older predates a failing reference
      if (!win_bad && lock_r) begin
        hist_new_r <= freq_int_r;
        hist_old_r <= hist_new_r;
      end
    end else begin
      win_cnt_r <= win_cnt_r + 17'h1;
      if (ref_edge && normal) begin
        win_seen_r <= 1'b1;
        if (over_thr)
          win_bad_r <= 1'b1;
      end
    end
  end

  // output stage: every output is a function of one accumulator
  wire [31:0] m193  = frame_ph_r * 32'hC1;
  wire [31:0] m2430 = frame_ph_r * 32'h97E;
  reg         fp_sel;
  always @* begin
    case (out_cfg_r[4:3])
      2'h1:    fp_sel = frame_ph_r < T_NAR[31:0];
      2'h2:    fp_sel = frame_ph_r < T_TINY[31:0];
      default: fp_sel = frame_ph_r < T_MID[31:0];
    endcase
  end
  reg         ck_sel;
  always @* begin
    case (out_cfg_r[1:0])
      2'h1:    ck_sel = frame_ph_r[21];
      2'h2:    ck_sel = frame_ph_r[20];
      2'h3:    ck_sel = frame_ph_r[19];
      default: ck_sel = frame_ph_r[22];
    endcase
  end

  // pulses narrower than a clock period still show for one cycle at wrap
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clk_out_a              <= 1'b0;
      clk_out_b              <= 1'b0;
      clk_out_c              <= 1'b0;
      clk_out_selectable     <= 1'b0;
      clk_out_line_rate      <= 1'b0;
      clk_out_sonet_rate     <= 1'b0;
      frame_pulse_wide       <= 1'b0;
      frame_pulse_mid        <= 1'b0;
      frame_pulse_narrow     <= 1'b0;
      frame_pulse_selectable <= 1'b0;
      frame_pulse_sonet      <= 1'b0;
    end else begin
      clk_out_a          <= frame_ph_r[22];
      clk_out_b          <= frame_ph_r[21];
      clk_out_c          <= frame_ph_r[20];
      clk_out_sonet_rate <= m2430[31];
      clk_out_selectable <= ck_sel;
      clk_out_line_rate  <= out_cfg_r[2] ? frame_ph_r[23] : m193[31];
      frame_pulse_wide   <= wrap | (frame_ph_r < T_WIDE[31:0]);
      frame_pulse_mid    <= wrap | (frame_ph_r < T_MID[31:0]);
      frame_pulse_narrow <= wrap | (frame_ph_r < T_NAR[31:0]);
      frame_pulse_selectable <= wrap | fp_sel;
      frame_pulse_sonet  <= wrap | (frame_ph_r < T_SON[31:0]);
    end
  end

  // apb slave: zero wait states, read data and error latched in setup
  wire setup  = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  wire mapped = (paddr[1:0] == 2'h0) && (paddr <= `DPSC_OFS_OCFG);
  assign pready = 1'b1;

  wire [31:0] status = {27'h0, mode, ref_sel, phase_realign_cmd, lock_r};
  reg  [31:0] rd_mux;
  always @* begin
    case (paddr)
      `DPSC_OFS_LR:   rd_mux = {18'h0, locking_range_reg};
      `DPSC_OFS_BW:   rd_mux = {16'h0, loop_bandwidth_ctrl_reg};
      `DPSC_OFS_THR:  rd_mux = {16'h0, lock_threshold_reg};
      `DPSC_OFS_INT:  rd_mux = {24'h0, lock_interval_reg};
      `DPSC_OFS_SLEW: rd_mux = {23'h0, slew_limit_reg};
      `DPSC_OFS_RCC:  rd_mux = {24'h0, ref_change_ctrl_reg};
      `DPSC_OFS_RCS:  rd_mux = status;
      `DPSC_OFS_OCFG: rd_mux = {24'h0, out_cfg_r};
      default:        rd_mux = 32'h0;
    endcase
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0 : rd_mux;
      pslverr <= ~mapped;
    end
  end

  // realign is cleared by the loop once the offset is dropped;
  // a write that sets it in that same cycle wins
  wire realign_done = ref_edge && normal && !rearr_r && started_r &&
                      phase_realign_cmd && !(mode != mode_d_r ||
                      ref_sel != sel_d_r);

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      locking_range_reg       <= `DPSC_RST_LR;
      loop_bandwidth_ctrl_reg <= `DPSC_RST_BW;
      lock_threshold_reg      <= `DPSC_RST_THR;
      lock_interval_reg       <= `DPSC_RST_INT;
      slew_limit_reg          <= `DPSC_RST_SLEW;
      ref_change_ctrl_reg     <= `DPSC_RST_RCC;
      out_cfg_r               <= `DPSC_RST_OCFG;
    end else begin
      if (realign_done)
        ref_change_ctrl_reg[`DPSC_RCC_REALIGN] <= 1'b0;
      if (wr_acc) begin
        case (paddr)
          `DPSC_OFS_LR:   locking_range_reg       <= pwdata[13:0];
          `DPSC_OFS_BW:   loop_bandwidth_ctrl_reg <= pwdata[15:0];
          `DPSC_OFS_THR:  lock_threshold_reg      <= pwdata[15:0];
          `DPSC_OFS_INT:  lock_interval_reg       <= pwdata[7:0];
          `DPSC_OFS_SLEW: slew_limit_reg          <= pwdata[8:0];
          `DPSC_OFS_RCC: begin
            ref_change_ctrl_reg[6:0] <= pwdata[6:0];
            if (pwdata[`DPSC_RCC_REALIGN])
              ref_change_ctrl_reg[`DPSC_RCC_REALIGN] <= 1'b1;
          end
          `DPSC_OFS_OCFG: out_cfg_r <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

endmodule // dpsc_top

`default_nettype wire

// ---- dv/dpsc_top_assertions.sv ----
// dpsc_top_assertions.sv: port-level checker bound into dpsc_top
// assumes apb on mclk and all frame outputs taken from one phase accumulator
`timescale 1ns/1ps
`default_nettype none
module dpsc_top_assertions #(
  parameter LOCK_WIN_CYC = 80000
) (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        clk_out_a,
  input wire logic        clk_out_b,
  input wire logic        clk_out_c,
  input wire logic        clk_out_selectable,
  input wire logic        frame_pulse_wide,
  input wire logic        frame_pulse_mid,
  input wire logic        frame_pulse_narrow,
  input wire logic        frame_pulse_selectable,
  input wire logic        frame_pulse_sonet
);
  // shadow of the output select field; outputs are registered, so compare one edge late
  logic [4:0] cfg_r;
  logic [4:0] cfg_d;
  wire setup = psel & ~penable;
  wire badad = (paddr > 8'h1C) | (paddr[1:0] != 2'h0);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= 5'h00;
      cfg_d <= 5'h00;
    end else begin
      if (psel && penable && pwrite && paddr == 8'h1C)
        cfg_r <= pwdata[4:0];
      cfg_d <= cfg_r;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_narrow_in_mid: assert property (frame_pulse_narrow |-> frame_pulse_mid)
    else $error("narrow pulse outside mid pulse");
  a_mid_in_wide: assert property (frame_pulse_mid |-> frame_pulse_wide)
    else $error("mid pulse outside wide pulse");
  a_sonet_in_wide: assert property (frame_pulse_sonet |-> frame_pulse_wide)
    else $error("sonet pulse not aligned to frame");
  a_mid_width: assert property ($rose(frame_pulse_mid) |-> ##[1:4] !frame_pulse_mid)
    else $error("mid pulse too long");
  a_wide_gap: assert property ($fell(frame_pulse_wide) |-> !frame_pulse_wide [*8])
    else $error("wide pulse repeats early");
  a_clk_sel_src: assert property ((cfg_r == cfg_d) |-> (cfg_d[1:0] == 2'h0 ?
    clk_out_selectable == clk_out_a : cfg_d[1:0] == 2'h1 ? clk_out_selectable == clk_out_b :
    cfg_d[1:0] == 2'h2 ? clk_out_selectable == clk_out_c : 1'b1))
    else $error("selectable clock source wrong");
  a_fp_sel_width: assert property ((cfg_r == cfg_d) |-> (cfg_d[4:3] == 2'h1 ?
    frame_pulse_selectable == frame_pulse_narrow : cfg_d[4:3] == 2'h2 ?
    (!frame_pulse_selectable || frame_pulse_narrow) :
    frame_pulse_selectable == frame_pulse_mid))
    else $error("selectable pulse width wrong");
  a_unmapped_err: assert property (setup && badad |=> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (setup && !badad |=>
    !pslverr && (pwrite || prdata[31:16] == 16'h0000))
    else $error("mapped access refused or upper bits set");
  a_err_zero: assert property (psel && penable && pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("refused read returned data");
  a_ready_now: assert property (setup |=> pready)
    else $error("access phase not ready");
endmodule // dpsc_top_assertions
bind dpsc_top dpsc_top_assertions #(.LOCK_WIN_CYC(LOCK_WIN_CYC)) u_chk (.mclk(mclk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .clk_out_a(clk_out_a),
  .clk_out_b(clk_out_b), .clk_out_c(clk_out_c), .clk_out_selectable(clk_out_selectable),
  .frame_pulse_wide(frame_pulse_wide), .frame_pulse_mid(frame_pulse_mid),
  .frame_pulse_narrow(frame_pulse_narrow), .frame_pulse_selectable(frame_pulse_selectable),
  .frame_pulse_sonet(frame_pulse_sonet));
`default_nettype wire

// ---- dv/dpsc_ref_src.sv ----
// dpsc_ref_src.sv: two 8 kHz reference sources facing the loop
// assumes a stopped source is held low; source 1 lags source 0 by 1 us
`timescale 1ns/1ps
`default_nettype none
module dpsc_ref_src (
  input  wire logic [1:0] run,
  output wire logic [1:0] ref_in
);
  localparam int HALF_NS = 62500;
  for (genvar i = 0; i < 2; i++) begin : g_src
    logic lvl;
    assign ref_in[i] = lvl;
    initial begin
      lvl = 1'b0;
      #(i * 1000);
      forever begin
        #(HALF_NS);
        lvl = run[i] ? ~lvl : 1'b0;
      end
    end
  end
endmodule // dpsc_ref_src
`default_nettype wire

// ---- dv/dpsc_top_tb.sv ----
// dpsc_top_tb.sv: self-checking bench for dpsc_top with a register model
// assumes dpsc_ref_src as far side and the bound port checker
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_defs.vh"
module dpsc_top_tb;
  localparam int WIN = 2600; // just over one reference period, keeps the run short
  logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0]  run, ref_in;
  int          n_errors, compares, cyc, i;
  integer      seed = 32'h5F93672C;
  int          rv [8] = '{`DPSC_RST_LR, `DPSC_RST_BW, `DPSC_RST_THR, `DPSC_RST_INT,
                          `DPSC_RST_SLEW, `DPSC_RST_RCC, 0, `DPSC_RST_OCFG};
  int          mdl [8];
  logic [7:0]  ofs [6] = '{`DPSC_OFS_LR, `DPSC_OFS_BW, `DPSC_OFS_THR, `DPSC_OFS_INT,
                          `DPSC_OFS_SLEW, `DPSC_OFS_OCFG};
  logic [31:0] msk [6] = '{32'h3FFF, 32'h200F, 32'hFFFF, 32'hFF, 32'h1FF, 32'h1F};
  logic [7:0]  bad_a [3] = '{8'h20, 8'h02, 8'hFC};
  localparam int LR_LO = 1544000 / `DPSC_FRAME_HZ; // rising edges per frame
  localparam int LR_HI = 2048000 / `DPSC_FRAME_HZ;
  localparam int SON_F = (`DPSC_MCLK_HZ - 19440000) / `DPSC_FRAME_HZ; // aliased by sampling
  logic        fpw, lr, son, fpw_d, lr_d, son_d, fr_ok;
  int          n_lr, n_son, ow_cnt, ow_snap;

  dpsc_top #(.LOCK_WIN_CYC(WIN)) dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_in(ref_in), .clk_out_a(), .clk_out_b(), .clk_out_c(),
    .clk_out_selectable(), .clk_out_line_rate(lr), .clk_out_sonet_rate(son),
    .frame_pulse_wide(fpw),
    .frame_pulse_mid(), .frame_pulse_narrow(), .frame_pulse_selectable(), .frame_pulse_sonet());
  dpsc_ref_src src (.run(run), .ref_in(ref_in));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic wrap_up;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 99000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // edges per frame; a frame overlapping an output-select write is skipped
  always @(posedge mclk) begin
    fpw_d <= fpw;
    lr_d <= lr;
    son_d <= son;
    if (!nrst) begin
      fr_ok <= 1'b0;
    end else if (fpw && !fpw_d) begin
      if (fr_ok && ow_snap == ow_cnt) begin
        chk(n_lr, mdl[7][2] ? LR_HI : LR_LO, "line rate edges");
        chk(n_son >= SON_F - 2 && n_son <= SON_F + 2, 1, "sonet edges");
      end
      fr_ok <= 1'b1;
      ow_snap <= ow_cnt;
      n_lr <= 0;
      n_son <= 0;
    end else begin
      n_lr <= n_lr + int'(lr && !lr_d);
      n_son <= n_son + int'(son && !son_d);
    end
  end

  function automatic logic bad(input logic [7:0] a);
    return a > 8'h1C || a[1:0] != 2'h0;
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    if (a == `DPSC_OFS_OCFG) ow_cnt++;
    apb(1'b1, a, d);
    chk(e, bad(a), "write error");
    if (!bad(a) && a != `DPSC_OFS_RCS)
      mdl[a[4:2]] = d;
    if (a == `DPSC_OFS_OCFG) ow_cnt++;
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk(q, bad(a) ? 32'h0 : mdl[a[4:2]], "read data");
    chk(e, bad(a), "read error");
  endtask

  task automatic wait_lock(input logic want, input int lim);
    int t = 0;
    do begin
      repeat (100) @(posedge mclk);
      apb(1'b0, `DPSC_OFS_RCS, 32'h0);
      t += 104;
    end while (q[`DPSC_RCS_LOCK] !== want && t < lim);
    chk(q[`DPSC_RCS_LOCK], want, "lock");
  endtask

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run = 2'b00;
    mdl = rv;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    for (i = 0; i < 8; i++) if (i != 6) rd(8'(i * 4));
    wr(`DPSC_OFS_RCS, 32'h1F);
    apb(1'b0, `DPSC_OFS_RCS, 32'h0);
    chk(q, 32'h0, "status");
    foreach (bad_a[j]) begin
      wr(bad_a[j], 32'hFFFF);
      rd(bad_a[j]);
    end
    // random settings, each held 300 cycles: enough for the checker to see the clock outputs, but under one 2500-cycle frame
    repeat (4) begin
      for (i = 0; i < 6; i++) wr(ofs[i], $random(seed) & msk[i]);
      for (i = 0; i < 8; i++) if (i != 6) rd(8'(i * 4));
      repeat (300) @(posedge mclk);
    end
    wr(`DPSC_OFS_SLEW, 32'h1FF);
    rd(`DPSC_OFS_SLEW);
    for (i = 0; i < 5; i++) wr(ofs[i], rv[i]);
    for (i = 0; i < 3; i++) begin
      wr(`DPSC_OFS_RCC, i);
      apb(1'b0, `DPSC_OFS_RCS, 32'h0);
      chk(q[4:3], i[1:0], "mode");
    end
    wr(`DPSC_OFS_RCC, 32'h0);
    wr(`DPSC_OFS_OCFG, 32'h0);
    run = 2'b01;
    repeat (2 * WIN) @(posedge mclk);
    apb(1'b0, `DPSC_OFS_RCS, 32'h0);
    chk(q[`DPSC_RCS_LOCK], 1'b0, "early lock");
    wait_lock(1'b1, 6 * WIN);
    wr(`DPSC_OFS_RCC, 32'h80);
    apb(1'b0, `DPSC_OFS_RCS, 32'h0);
    chk(q[`DPSC_RCS_BUSY], 1'b1, "realign pending");
    wr(`DPSC_OFS_OCFG, 32'hC);
    repeat (5200) @(posedge mclk);
    apb(1'b0, `DPSC_OFS_RCS, 32'h0);
    chk(q[`DPSC_RCS_BUSY], 1'b0, "realign done");
    mdl[5] = 0;
    rd(`DPSC_OFS_RCC);
    wr(`DPSC_OFS_RCC, 32'h1);
    wait_lock(1'b0, 3 * WIN);
    wr(`DPSC_OFS_RCC, 32'h4);
    run = 2'b11;
    apb(1'b0, `DPSC_OFS_RCS, 32'h0);
    chk(q[`DPSC_RCS_REFSEL], 1'b1, "ref select");
    wait_lock(1'b1, 9 * WIN);
    run = 2'b00;
    wait_lock(1'b0, 3 * WIN);
    wrap_up();
  end
endmodule // dpsc_top_tb
`default_nettype wire
